// >>> logic/dmc_core.sv
`timescale 1ns/1ps
// Behaviour
// - Bus width bit low: upper byte ignored, assembly shifts eight per write.
// - Bus width bit high: assembly shifts sixteen per write.
// - Sleep stops the datapath and turns the DAC current off.
// - Amplitude enable low: sine value goes straight to the DAC.
// - Amplitude enable high: I/Q multipliers shape the output.
// - Sync bypass low: select, load, code pass a four-stage pipeline.
// - Sync bypass high: select, load, code used directly.
// - Command register loads only from the parallel assembly register.
// - 32-bit accumulator, full word is one cycle of phase.
// - Step is frequency word zero or one per frequency select.
// - Changing frequency word never resets or jumps the accumulator.
// - Phase offset word is added to the accumulator top bits.
// - Only the top 12 offset phase bits address the tables.
// - Cosine scaled by amplitude bits 9:0, sine by bits 19:10.
// - I plus Q sum wraps in 10 bits, never saturates.
// - Reset clears command and all modulation registers.
// - Latencies 14, 13, 11 cycles; four fewer without synchroniser.
module dmc_core (
    input  wire logic        i_mclk,
    input  wire logic        i_rst_n,
    input  wire logic [15:0] i_data,
    input  wire logic        i_wr,
    input  wire logic        i_ser_bit,
    input  wire logic        i_ser_shift,
    input  wire logic        i_load,
    input  wire logic [3:0]  i_transfer_code,
    input  wire logic        i_frequency_select,
    input  wire logic        i_sleep_pin,
    output logic      [9:0]  o_dac,
    output logic             o_dac_on,
    output logic      [3:0]  o_command_control
);
    logic [31:0] par_asm;
    logic [31:0] ser_asm;
    logic [31:0] frequency_word_zero;
    logic [31:0] frequency_word_one;
    logic [11:0] phase_offset_word;
    logic [19:0] iq_amplitude_word;
    logic [5:0]  ctl_raw;
    logic [5:0]  sync_pipe [dmc_pkg::SYNC_STAGES];
    logic [5:0]  ctl_eff;
    logic        frequency_select;
    logic        load_eff;
    logic [3:0]  transfer_code;
    logic        sleeping;
    logic [31:0] src_word;
    logic [2:0]  fsel_dly;
    logic [31:0] step;
    logic [31:0] acc;
    logic [11:0] phase_dly [dmc_pkg::ALIGN_DLY];
    logic [19:0] iq_dly [dmc_pkg::ALIGN_DLY];
    logic [11:0] phase_sum;
    logic [9:0]  prod_i;
    logic [9:0]  prod_q;
    logic [9:0]  sine_d1;
    logic [9:0]  iq_sum;
    logic [9:0]  sine_d2;
    logic [2:0]  up_cnt;
    logic [9:0]  exp_iq;

    dmc_rom_if rom_bus ();

    dmc_rom u_rom (
        .i_mclk  (i_mclk),
        .i_rst_n (i_rst_n),
        .bus     (rom_bus.rom)
    );

    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_rst_n);

    // Pin control and sleep decode
    assign ctl_raw  = {i_frequency_select, i_load, i_transfer_code};
    assign ctl_eff  = o_command_control[dmc_pkg::CR_SYNC] ? ctl_raw
                    : sync_pipe[dmc_pkg::SYNC_STAGES-1];
    assign frequency_select = ctl_eff[5];
    assign load_eff         = ctl_eff[4];
    assign transfer_code    = ctl_eff[3:0];
    assign sleeping = o_command_control[dmc_pkg::CR_SLEEP] | i_sleep_pin;
    assign src_word = transfer_code[2] ? ser_asm : par_asm;

    // Four-stage synchroniser for select, load and transfer code
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            for (int i = 0; i < dmc_pkg::SYNC_STAGES; i++) begin
                sync_pipe[i] <= 6'h00;
            end
        end else begin
            sync_pipe[0] <= ctl_raw;
            for (int i = 1; i < dmc_pkg::SYNC_STAGES; i++) begin
                sync_pipe[i] <= sync_pipe[i-1];
            end
        end
    end

    // Parallel assembly register
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            par_asm <= dmc_pkg::WORD_RST;
        end else if (i_wr) begin
            if (o_command_control[dmc_pkg::CR_BUS]) begin
                par_asm <= {par_asm[15:0], i_data};
            end else begin
                par_asm <= {par_asm[23:0], i_data[7:0]};
            end
        end
    end

    // Serial assembly register, msb first
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ser_asm <= dmc_pkg::WORD_RST;
        end else if (i_ser_shift) begin
            ser_asm <= {ser_asm[30:0], i_ser_bit};
        end
    end

    // Command register, parallel source only
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_command_control <= dmc_pkg::CMD_RST;
        end else if (load_eff && transfer_code[3:2] == dmc_pkg::TC_CMD) begin
            o_command_control <= par_asm[3:0];
        end
    end

    // Modulation registers from either assembly register
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            frequency_word_zero <= dmc_pkg::WORD_RST;
            frequency_word_one  <= dmc_pkg::WORD_RST;
            phase_offset_word   <= 12'h000;
            iq_amplitude_word   <= 20'h00000;
        end else if (load_eff && transfer_code[3]) begin
            case (transfer_code[1:0])
                dmc_pkg::DST_F0: frequency_word_zero <= src_word;
                dmc_pkg::DST_F1: frequency_word_one  <= src_word;
                dmc_pkg::DST_PH: phase_offset_word   <= src_word[11:0];
                dmc_pkg::DST_IQ: iq_amplitude_word   <= src_word[19:0];
                default: frequency_word_zero <= frequency_word_zero;
            endcase
        end
    end

    // Alignment delays so each path meets its latency
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            fsel_dly <= 3'h0;
            for (int i = 0; i < dmc_pkg::ALIGN_DLY; i++) begin
                phase_dly[i] <= 12'h000;
                iq_dly[i]    <= 20'h00000;
            end
        end else if (!sleeping) begin
            fsel_dly     <= {fsel_dly[1:0], frequency_select};
            phase_dly[0] <= phase_offset_word;
            iq_dly[0]    <= iq_amplitude_word;
            for (int i = 1; i < dmc_pkg::ALIGN_DLY; i++) begin
                phase_dly[i] <= phase_dly[i-1];
                iq_dly[i]    <= iq_dly[i-1];
            end
        end
    end

    // Step select and phase accumulator
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            step <= dmc_pkg::WORD_RST;
            acc  <= dmc_pkg::WORD_RST;
        end else if (!sleeping) begin
            step <= fsel_dly[2] ? frequency_word_one
                                : frequency_word_zero;
            acc  <= acc + step;
        end
    end

    // Phase offset add, top bits only address the tables
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            phase_sum <= 12'h000;
        end else if (!sleeping) begin
            phase_sum <= acc[31:20] + phase_dly[2];
        end
    end
    assign rom_bus.addr = phase_sum;
    assign rom_bus.hold = sleeping;

    // I/Q multipliers and wrapping sum
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            prod_i  <= 10'h000;
            prod_q  <= 10'h000;
            sine_d1 <= 10'h000;
            iq_sum  <= 10'h000;
            sine_d2 <= 10'h000;
        end else if (!sleeping) begin
            prod_i  <= dmc_pkg::dmc_scale(rom_bus.cos_val,
                                          iq_dly[2][9:0]);
            prod_q  <= dmc_pkg::dmc_scale(rom_bus.sin_val,
                                          iq_dly[2][19:10]);
            sine_d1 <= rom_bus.sin_val;
            iq_sum  <= prod_i + prod_q;
            sine_d2 <= sine_d1;
        end
    end

    // Output select and DAC current enable
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_dac    <= 10'h000;
            o_dac_on <= 1'b0;
        end else begin
            o_dac_on <= !sleeping;
            if (!sleeping) begin
                if (o_command_control[dmc_pkg::CR_AM]) begin
                    o_dac <= iq_sum;
                end else begin
                    o_dac <= sine_d2;
                end
            end
        end
    end

    // Cycles since reset release, for checks only
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            up_cnt <= 3'h0;
        end else if (up_cnt != 3'h7) begin
            up_cnt <= up_cnt + 3'h1;
        end
    end

    // Expected I/Q sum from table outputs
    assign exp_iq = dmc_pkg::dmc_scale(rom_bus.cos_val, iq_dly[2][9:0])
                  + dmc_pkg::dmc_scale(rom_bus.sin_val, iq_dly[2][19:10]);

    // Checks on assembly and command loading
    width8_shift_a: assert property (
        i_wr && !o_command_control[0]
        |=> par_asm == {$past(par_asm[23:0]), $past(i_data[7:0])})
        else $error("eight-bit shift wrong");
    width16_shift_a: assert property (
        i_wr && o_command_control[0]
        |=> par_asm == {$past(par_asm[15:0]), $past(i_data)})
        else $error("sixteen-bit shift wrong");
    cmd_source_a: assert property (
        load_eff && transfer_code[3:2] == 2'h0
        |=> o_command_control == $past(par_asm[3:0]))
        else $error("command not taken from parallel");
    reset_clear_a: assert property (
        $rose(up_cnt == 3'h1) |-> o_command_control == 4'h0
        && frequency_word_zero == 32'h0 && iq_amplitude_word == 20'h0)
        else $error("registers not cleared by reset");

    // Checks on control synchroniser
    sync_delay_a: assert property (
        up_cnt == 3'h7 && !o_command_control[3]
        |-> frequency_select == $past(i_frequency_select, 4))
        else $error("synchroniser delay not four");
    sync_bypass_a: assert property (
        o_command_control[3] |-> load_eff == i_load
        && frequency_select == i_frequency_select)
        else $error("bypass not direct");

    // Checks on accumulator and phase path
    sleep_hold_a: assert property (
        sleeping |=> acc == $past(acc) && !o_dac_on)
        else $error("sleep did not freeze");
    acc_step_a: assert property (
        !sleeping |=> acc == 32'($past(acc) + $past(step)))
        else $error("accumulator step wrong");
    phase_addr_a: assert property (
        !sleeping |=> rom_bus.addr == 12'($past(acc[31:20])
                                      + $past(phase_dly[2])))
        else $error("phase offset add wrong");

    // Checks on the output select
    am_bypass_a: assert property (
        (!sleeping) [*3] ##0 !o_command_control[2]
        |=> o_dac == $past(rom_bus.sin_val, 3))
        else $error("sine bypass wrong");
    iq_sum_a: assert property (
        (!sleeping) [*3] ##0 o_command_control[2]
        |=> o_dac == $past(exp_iq, 3))
        else $error("I/Q sum wrong");

    // Main scenarios
    fsk_switch_c: cover property (
        !sleeping && $changed(frequency_select));
    am_active_c: cover property (
        o_command_control[2] && o_dac_on && iq_sum != 10'h000);
    sleep_entry_c: cover property ($fell(o_dac_on));
    serial_load_c: cover property (
        load_eff && transfer_code[3:2] == 2'h3);
endmodule

// >>> logic/dmc_pkg.sv
package dmc_pkg;
    // Datapath widths
    localparam int ACC_W  = 32;
    localparam int PH_W   = 12;
    localparam int AMP_W  = 10;
    localparam int DAT_W  = 16;
    localparam int IQ_W   = 20;
    localparam int CMD_W  = 4;
    // Command register bit positions
    localparam int CR_BUS   = 0;
    localparam int CR_SLEEP = 1;
    localparam int CR_AM    = 2;
    localparam int CR_SYNC  = 3;
    // Reset values
    localparam logic [CMD_W-1:0] CMD_RST  = 4'h0;
    localparam logic [ACC_W-1:0] WORD_RST = 32'h0;
    // Transfer code groups (upper two bits)
    localparam logic [1:0] TC_CMD = 2'h0;
    localparam logic [1:0] TC_PAR = 2'h2;
    localparam logic [1:0] TC_SER = 2'h3;
    // Destination select (lower two bits)
    localparam logic [1:0] DST_F0 = 2'h0;
    localparam logic [1:0] DST_F1 = 2'h1;
    localparam logic [1:0] DST_PH = 2'h2;
    localparam logic [1:0] DST_IQ = 2'h3;
    // Pipeline timing in clock cycles
    localparam int SYNC_STAGES = 4;
    localparam int ALIGN_DLY   = 3;
    localparam int LAT_FSEL    = 14;
    localparam int LAT_PHASE   = 13;
    localparam int LAT_AMP     = 11;
    // Lookup table shape
    localparam int ROM_DEPTH = 4096;
    localparam int ROM_PEAK  = 511;
    localparam logic [PH_W-1:0] COS_OFS = 12'h400;

    // Signed fractional scaling, result in the same Q1.9 format
    function automatic logic [AMP_W-1:0] dmc_scale(
        input logic signed [AMP_W-1:0] v,
        input logic signed [AMP_W-1:0] a);
        logic signed [2*AMP_W-1:0] p;
        p = v * a;
        return p[2*AMP_W-2:AMP_W-1];
    endfunction
endpackage

// >>> logic/dmc_rom_if.sv
`timescale 1ns/1ps
interface dmc_rom_if;
    logic [11:0] addr;
    logic        hold;
    logic [9:0]  sin_val;
    logic [9:0]  cos_val;
    modport core (output addr, output hold, input sin_val, input cos_val);
    modport rom  (input addr, input hold, output sin_val, output cos_val);
endinterface

// >>> logic/dmc_rom.sv
`timescale 1ns/1ps
module dmc_rom (
    input  wire logic i_mclk,
    input  wire logic i_rst_n,
    dmc_rom_if.rom    bus
);
    logic [9:0] tbl [dmc_pkg::ROM_DEPTH];

    // Sine table filled once at elaboration
    initial begin
        for (int i = 0; i < dmc_pkg::ROM_DEPTH; i++) begin
            tbl[i] = 10'($rtoi($floor(dmc_pkg::ROM_PEAK *
                $sin(6.283185307179586 * i / dmc_pkg::ROM_DEPTH) + 0.5)));
        end
    end

    // Registered sine and cosine reads, frozen while asleep
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            bus.sin_val <= 10'h000;
            bus.cos_val <= 10'h000;
        end else if (!bus.hold) begin
            bus.sin_val <= tbl[bus.addr];
            bus.cos_val <= tbl[12'(bus.addr + dmc_pkg::COS_OFS)];
        end
    end
endmodule

// >>> verif/dmc_host.sv
`timescale 1ns/1ps
module dmc_host (
    input  wire logic        i_mclk,
    output logic      [15:0] o_data,
    output logic             o_wr,
    output logic             o_ser_bit,
    output logic             o_ser_shift,
    output logic             o_load,
    output logic      [3:0]  o_transfer_code,
    output logic             o_frequency_select,
    output logic             o_sleep_pin
);
    // Idle levels from time zero
    initial begin
        o_data = 16'h0;
        o_wr = 1'b0;
        o_ser_bit = 1'b0;
        o_ser_shift = 1'b0;
        o_load = 1'b0;
        o_transfer_code = 4'h0;
        o_frequency_select = 1'b0;
        o_sleep_pin = 1'b0;
    end

    // Parallel word, released bus shows the inverse
    task automatic wr(input logic [15:0] d);
        @(negedge i_mclk);
        o_data = d;
        o_wr = 1'b1;
        @(negedge i_mclk);
        o_wr = 1'b0;
        o_data = ~d;
    endtask

    // Serial word, msb first
    task automatic sh(input logic [31:0] w);
        for (int i = 31; i >= 0; i--) begin
            @(negedge i_mclk);
            o_ser_bit = w[i];
            o_ser_shift = 1'b1;
        end
        @(negedge i_mclk);
        o_ser_shift = 1'b0;
        o_ser_bit = ~o_ser_bit;
    endtask

    // Code set up ahead of load and held past it
    task automatic xf(input logic [3:0] c);
        @(negedge i_mclk);
        o_transfer_code = c;
        @(negedge i_mclk);
        o_load = 1'b1;
        @(negedge i_mclk);
        o_load = 1'b0;
    endtask
endmodule

// >>> verif/dmc_core_bench.sv
`timescale 1ns/1ps
module dmc_core_bench;
    logic        i_mclk;
    logic        i_rst_n;
    logic [15:0] d;
    logic        wr, sb, ss, ld, fs, sp;
    logic [3:0]  tc;
    logic [9:0]  o_dac;
    logic        o_dac_on;
    logic [3:0]  cmd;
    logic [9:0]  v;
    logic [19:0] iq [4];
    int          n_errors;
    int          check_count;
    int          k;

    dmc_host host (.i_mclk(i_mclk), .o_data(d), .o_wr(wr),
        .o_ser_bit(sb), .o_ser_shift(ss), .o_load(ld),
        .o_transfer_code(tc), .o_frequency_select(fs),
        .o_sleep_pin(sp));
    dmc_core dut (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_data(d),
        .i_wr(wr), .i_ser_bit(sb), .i_ser_shift(ss), .i_load(ld),
        .i_transfer_code(tc), .i_frequency_select(fs),
        .i_sleep_pin(sp), .o_dac(o_dac), .o_dac_on(o_dac_on),
        .o_command_control(cmd));

    // Reference clock
    initial begin
        i_mclk = 1'b0;
        forever #5 i_mclk = ~i_mclk;
    end

    // Table entry, rounded away from zero
    function automatic logic [9:0] sn(input int n);
        real r;
        r = 511.0 * $sin(2.0 * 3.141592653589793 * n / 4096.0);
        return 10'($rtoi(r < 0.0 ? r - 0.5 : r + 0.5));
    endfunction

    // Fractional product, bits 18:9
    function automatic logic [9:0] sc(input logic [9:0] x,
                                      input logic [9:0] a);
        logic signed [19:0] p;
        p = $signed(x) * $signed(a);
        return p[18:9];
    endfunction

    task automatic chk(input string nm, input logic [9:0] e,
                       input logic [9:0] s);
        check_count++;
        if (s !== e) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic wrap_up;
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // Edges from a pin change until the output moves
    task automatic mw(input int e);
        logic [9:0] s;
        int         n;
        s = o_dac;
        n = 0;
        while (o_dac === s && n < 40) begin
            @(posedge i_mclk);
            #1;
            n++;
        end
        chk("latency", 10'(e), 10'(n));
    endtask

    task automatic xfm(input logic [3:0] c, input int e);
        fork
            host.xf(c);
        join_none
        @(posedge ld);
        mw(e);
    endtask

    task automatic w2(input logic [31:0] w);
        host.wr(w[31:16]);
        host.wr(w[15:0]);
    endtask

    // Quadrant of a quarter-turn stepping output
    task automatic qd(output int q);
        q = 0;
        for (int j = 0; j < 4; j++)
            if (o_dac === sn(291 + 1024 * j))
                q = j;
    endtask

    // Watchdog
    initial begin
        #300000;
        n_errors++;
        wrap_up();
    end

    initial begin
        iq = '{20'h7fdff, 20'h80000, 20'h00100, 20'h403c0};
        n_errors = 0;
        check_count = 0;
        i_rst_n = 1'b0;
        repeat (16) @(negedge i_mclk);
        chk("cmd", {6'h0, cmd}, 10'h0);
        chk("dac", 10'h0, o_dac);
        i_rst_n = 1'b1;
        @(negedge i_mclk);
        chk("dac_on", 10'h1, {9'h0, o_dac_on});
        // Byte mode, synchroniser on, upper byte dropped
        host.wr(16'hff02);
        host.wr(16'hff34);
        xfm(4'ha, 13);
        chk("dac", sn(12'h234), o_dac);
        host.sh(32'h0000000f);
        host.wr(16'hff08);
        host.xf(4'h0);
        repeat (6) @(negedge i_mclk);
        chk("cmd", 10'h8, {6'h0, cmd});
        host.sh(32'h00000456);
        host.xf(4'he);
        repeat (12) @(negedge i_mclk);
        chk("dac", sn(12'h456), o_dac);
        // Word mode, bypassed synchroniser
        host.wr(16'h0009);
        host.xf(4'h0);
        w2(32'h0abc0123);
        xfm(4'ha, 9);
        chk("dac", sn(12'h123), o_dac);
        w2(32'h40000000);
        host.xf(4'h8);
        repeat (12) @(negedge i_mclk);
        qd(k);
        for (int j = 0; j < 4; j++) begin
            chk("step", sn(291 + 1024 * ((k + j) % 4)), o_dac);
            @(negedge i_mclk);
        end
        // Select word one, still zero: output freezes in quadrant
        host.o_frequency_select = 1'b1;
        repeat (16) @(negedge i_mclk);
        qd(k);
        v = o_dac;
        repeat (3) @(negedge i_mclk);
        chk("frozen", v, o_dac);
        chk("continuous", sn(291 + 1024 * k), v);
        host.o_frequency_select = 1'b0;
        mw(10);
        // Sleep by pin, then by command bit
        @(negedge i_mclk);
        host.o_sleep_pin = 1'b1;
        @(negedge i_mclk);
        chk("dac_on", 10'h0, {9'h0, o_dac_on});
        v = o_dac;
        repeat (4) @(negedge i_mclk);
        chk("held", v, o_dac);
        host.o_sleep_pin = 1'b0;
        repeat (2) @(negedge i_mclk);
        chk("dac_on", 10'h1, {9'h0, o_dac_on});
        host.wr(16'h000b);
        host.xf(4'h0);
        repeat (2) @(negedge i_mclk);
        chk("cmd", 10'hb, {6'h0, cmd});
        chk("dac_on", 10'h0, {9'h0, o_dac_on});
        // Second reset, then amplitude products
        i_rst_n = 1'b0;
        @(negedge i_mclk);
        chk("cmd", 10'h0, {6'h0, cmd});
        i_rst_n = 1'b1;
        host.wr(16'h000d);
        host.xf(4'h0);
        repeat (6) @(negedge i_mclk);
        w2(32'h00000200);
        host.xf(4'ha);
        repeat (12) @(negedge i_mclk);
        chk("am zero", 10'h0, o_dac);
        for (int j = 0; j < 4; j++) begin
            w2({12'h0, iq[j]});
            xfm(4'hb, 7);
            chk("am", sc(sn(12'h600), iq[j][9:0])
                + sc(sn(12'h200), iq[j][19:10]), o_dac);
        end
        wrap_up();
    end
endmodule
